/* eac_cfg.svh */
// constants of the data-memory access block: offsets, fields, codes, timings
// assumes inclusion by bare name from the package and the top module
`ifndef EAC_CFG_SVH
`define EAC_CFG_SVH

// i/o offsets
`define EAC_OFF_SCRATCH0    6'h13
`define EAC_OFF_SCRATCH1    6'h14
`define EAC_OFF_SCRATCH2    6'h15
`define EAC_OFF_CONTROL     6'h1C
`define EAC_OFF_DATA        6'h1D
`define EAC_OFF_ADDR_LOW    6'h1E
`define EAC_OFF_ADDR_HIGH   6'h1F

// control field positions
`define EAC_BIT_MODE_HI     5
`define EAC_BIT_MODE_LO     4
`define EAC_BIT_RDY_IE      3
`define EAC_BIT_MPE         2
`define EAC_BIT_PE          1
`define EAC_BIT_RE          0

// programming mode codes
`define EAC_MODE_ATOMIC     2'h0
`define EAC_MODE_ERASE      2'h1
`define EAC_MODE_WRITE      2'h2
`define EAC_MODE_RSVD       2'h3

// reset and erased values
`define EAC_RST_BYTE        8'h00
`define EAC_RST_MODE        2'h0
`define EAC_ERASED_BYTE     8'hFF

// timing
`define EAC_T_ATOMIC_US     3400
`define EAC_T_SPLIT_US      1800
`define EAC_MPE_WINDOW      3'h4
`define EAC_STALL_PROG      3'h2
`define EAC_STALL_READ      3'h4

`endif

/* eac_pkg.sv */
// types of the data-memory access block
// assumes eac_cfg.svh is on the include path
`include "eac_cfg.svh"

package eac_pkg;
	typedef enum logic {
		EAC_IDLE,
		EAC_PROG
	} eac_state_e;

	typedef logic [1:0] eac_mode_t;
endpackage

/* eac_top.sv */
// data-memory access control: address, data, control and scratch registers
// assumes a core on clock_in doing single-cycle i/o writes and reads
//
// What this block does
// - High address register reads zero on bits 7..1; bit 0 only in largest size.
// - Low address bit 7 exists in the middle size, reads zero in the smallest.
// - Bytes are addressed linearly from zero over 128, 256 or 512 bytes.
// - Data register holds the byte to program, and the byte fetched by a read.
// - Control bits 7 and 6 always read zero; software writes zero there.
// - Mode field 5:4 picks atomic 3.4 ms, erase 1.8 ms, write 1.8 ms, or reserved.
// - Writes to the mode field are ignored while programming is busy.
// - Reset clears the mode field to 00 unless programming is in progress.
// - Ready interrupt is a level while enabled, globally enabled and not busy.
// - Program enable starts only within four cycles of a master enable set.
// - Master enable clears itself four cycles after software sets it.
// - Valid program enable launches the mode's operation and stays set while busy.
// - Setting program enable stalls the core for two cycles.
// - Read strobe loads the addressed byte into the data register at once.
// - A read strobe stalls the core for four cycles.
// - While busy, read strobes are refused and address writes are ignored.
// - Three zero-reset scratch registers at 0x13, 0x14 and 0x15.
// - A reset during programming lets the operation finish.
`timescale 1ns/1ps
`default_nettype none
`include "eac_cfg.svh"

module eac_top #(
	parameter int ADDR_BITS   = 9,
	parameter int CLK_HZ      = 125000000,
	parameter int ATOMIC_CYC  = (CLK_HZ / 1000000) * `EAC_T_ATOMIC_US,
	parameter int SPLIT_CYC   = (CLK_HZ / 1000000) * `EAC_T_SPLIT_US
) (
	// clock and resets
	input  wire logic       clock_in,
	input  wire logic       reset_n_in,
	input  wire logic       por_n_in,
	// i/o register port
	input  wire logic [5:0] io_addr_in,
	input  wire logic [7:0] io_wdata_in,
	input  wire logic       io_we_in,
	input  wire logic       io_re_in,
	output logic      [7:0] io_rdata_out,
	// core interface
	input  wire logic       global_irq_in,
	output logic            ready_irq_out,
	output logic            cpu_stall_out,
	output logic            busy_out
);

	localparam int DEPTH = 1 << ADDR_BITS;

	// refuse sizes and counts the logic cannot serve
	if (ADDR_BITS < 7 || ADDR_BITS > 9) begin : g_bad_size
		$error("eac_top: ADDR_BITS must be 7, 8 or 9");
	end
	if (SPLIT_CYC < 1 || ATOMIC_CYC < SPLIT_CYC) begin : g_bad_count
		$error("eac_top: programming counts out of range");
	end

	// nonvolatile byte array, never reset
	logic [7:0]           mem [DEPTH];

	// chip-reset domain registers
	logic [7:0]           scratch_reg_0;
	logic [7:0]           scratch_reg_1;
	logic [7:0]           scratch_reg_2;
	logic [ADDR_BITS-1:0] nvm_address;
	logic [7:0]           nvm_data;
	logic                 ready_irq_enable;
	logic                 master_prog_enable;
	logic [2:0]           mpe_count;
	logic [2:0]           stall_count;

	// power-on domain: programming engine survives chip reset
	logic                 chip_rst_meta;
	logic                 chip_rst_sync;
	eac_pkg::eac_mode_t   prog_mode_field;
	eac_pkg::eac_state_e  state;
	logic [31:0]          prog_count;
	logic [ADDR_BITS-1:0] prog_addr;
	logic [7:0]           prog_byte;
	eac_pkg::eac_mode_t   prog_op;

	function automatic logic hit(input logic [5:0] a, input logic [5:0] off);
		return a == off;
	endfunction

	// decode
	wire       wr_scr0  = io_we_in && hit(io_addr_in, `EAC_OFF_SCRATCH0);
	wire       wr_scr1  = io_we_in && hit(io_addr_in, `EAC_OFF_SCRATCH1);
	wire       wr_scr2  = io_we_in && hit(io_addr_in, `EAC_OFF_SCRATCH2);
	wire       wr_ctrl  = io_we_in && hit(io_addr_in, `EAC_OFF_CONTROL);
	wire       wr_data  = io_we_in && hit(io_addr_in, `EAC_OFF_DATA);
	wire       wr_addrl = io_we_in && hit(io_addr_in, `EAC_OFF_ADDR_LOW);
	wire       wr_addrh = io_we_in && hit(io_addr_in, `EAC_OFF_ADDR_HIGH);
	wire       busy     = (state == eac_pkg::EAC_PROG);

	wire       addr_wr_ok = !busy;
	wire       read_go    = wr_ctrl && io_wdata_in[`EAC_BIT_RE] && !busy;
	wire [1:0] wr_mode    = io_wdata_in[`EAC_BIT_MODE_HI:`EAC_BIT_MODE_LO];
	wire       prog_go    = wr_ctrl && io_wdata_in[`EAC_BIT_PE] && !busy
	                        && master_prog_enable
	                        && prog_mode_field != `EAC_MODE_RSVD;
	wire       mpe_set    = wr_ctrl && io_wdata_in[`EAC_BIT_MPE];

	// address register views by variant
	wire       addr_top   = (ADDR_BITS == 9) ? nvm_address[ADDR_BITS-1] : 1'b0;
	wire       addr_seven = (ADDR_BITS >= 8) ? nvm_address[7 % ADDR_BITS] : 1'b0;
	wire [7:0] addr_low_rd  = {addr_seven, nvm_address[6:0]};
	wire [7:0] addr_high_rd = {7'h00, addr_top};
	wire [7:0] ctrl_rd      = {2'h0, prog_mode_field, ready_irq_enable,
	                           master_prog_enable, busy, 1'b0};

	// next address: low byte fills bits 7..0, high bit 0 fills bit 8
	wire [15:0] addr_wide = {7'h00, wr_addrh ? io_wdata_in[0] : addr_top,
	                         wr_addrl ? io_wdata_in : addr_low_rd};
	wire [ADDR_BITS-1:0] next_nvm_address = addr_wide[ADDR_BITS-1:0];

	// committed byte at end of programming
	wire [7:0] mem_old   = mem[prog_addr];
	wire [7:0] next_byte = (prog_op == `EAC_MODE_ERASE) ? `EAC_ERASED_BYTE :
	                       (prog_op == `EAC_MODE_WRITE) ? (mem_old & prog_byte) :
	                       prog_byte;
	wire [31:0] prog_len = (prog_mode_field == `EAC_MODE_ATOMIC) ?
	                       32'(ATOMIC_CYC) : 32'(SPLIT_CYC);
	wire        prog_done = busy && prog_count == 32'h1;

	wire [7:0] next_rdata =
		hit(io_addr_in, `EAC_OFF_SCRATCH0)  ? scratch_reg_0 :
		hit(io_addr_in, `EAC_OFF_SCRATCH1)  ? scratch_reg_1 :
		hit(io_addr_in, `EAC_OFF_SCRATCH2)  ? scratch_reg_2 :
		hit(io_addr_in, `EAC_OFF_CONTROL)   ? ctrl_rd :
		hit(io_addr_in, `EAC_OFF_DATA)      ? nvm_data :
		hit(io_addr_in, `EAC_OFF_ADDR_LOW)  ? addr_low_rd :
		hit(io_addr_in, `EAC_OFF_ADDR_HIGH) ? addr_high_rd : `EAC_RST_BYTE;

	// next values of the registered core outputs
	wire       next_ready_irq = ready_irq_enable && global_irq_in && !(busy && !prog_done);
	wire       next_stall     = read_go || prog_go || stall_count > 3'h1;
	wire       next_busy      = (busy && !prog_done) || prog_go;

	// scratch registers, no side effects
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scratch_reg_0 <= `EAC_RST_BYTE;
			scratch_reg_1 <= `EAC_RST_BYTE;
			scratch_reg_2 <= `EAC_RST_BYTE;
		end else begin
			if (wr_scr0)
				scratch_reg_0 <= io_wdata_in;
			if (wr_scr1)
				scratch_reg_1 <= io_wdata_in;
			if (wr_scr2)
				scratch_reg_2 <= io_wdata_in;
		end
	end

	// address and data registers
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			nvm_address <= '0;
			nvm_data    <= `EAC_RST_BYTE;
		end else begin
			if ((wr_addrl || wr_addrh) && addr_wr_ok)
				nvm_address <= next_nvm_address;
			if (read_go)
				nvm_data <= mem[nvm_address];
			else if (wr_data)
				nvm_data <= io_wdata_in;
		end
	end

	// interrupt enable and master enable window
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			ready_irq_enable   <= 1'b0;
			master_prog_enable <= 1'b0;
			mpe_count          <= 3'h0;
		end else begin
			if (wr_ctrl)
				ready_irq_enable <= io_wdata_in[`EAC_BIT_RDY_IE];
			if (mpe_set) begin
				master_prog_enable <= 1'b1;
				mpe_count          <= `EAC_MPE_WINDOW;
			end else if (mpe_count != 3'h0) begin
				mpe_count <= mpe_count - 3'h1;
				if (mpe_count == 3'h1)
					master_prog_enable <= 1'b0;
			end
		end
	end

	// core stall after a program start or a read strobe
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in)
			stall_count <= 3'h0;
		else if (read_go)
			stall_count <= `EAC_STALL_READ;
		else if (prog_go)
			stall_count <= `EAC_STALL_PROG;
		else if (stall_count != 3'h0)
			stall_count <= stall_count - 3'h1;
	end

	// chip reset seen by the programming engine
	always_ff @(posedge clock_in or negedge por_n_in) begin
		if (!por_n_in) begin
			chip_rst_meta <= 1'b1;
			chip_rst_sync <= 1'b1;
		end else begin
			chip_rst_meta <= !reset_n_in;
			chip_rst_sync <= chip_rst_meta;
		end
	end

	// mode field: cleared by chip reset only when idle
	always_ff @(posedge clock_in or negedge por_n_in) begin
		if (!por_n_in)
			prog_mode_field <= `EAC_RST_MODE;
		else if (chip_rst_sync && !busy)
			prog_mode_field <= `EAC_RST_MODE;
		else if (wr_ctrl && !busy)
			prog_mode_field <= wr_mode;
	end

	// programming engine, untouched by chip reset
	always_ff @(posedge clock_in or negedge por_n_in) begin
		if (!por_n_in) begin
			state      <= eac_pkg::EAC_IDLE;
			prog_count <= 32'h0;
			prog_addr  <= '0;
			prog_byte  <= `EAC_RST_BYTE;
			prog_op    <= `EAC_RST_MODE;
		end else begin
			unique case (state)
				eac_pkg::EAC_IDLE: begin
					if (prog_go) begin
						state      <= eac_pkg::EAC_PROG;
						prog_count <= prog_len;
						prog_addr  <= nvm_address;
						prog_byte  <= nvm_data;
						prog_op    <= prog_mode_field;
					end
				end
				eac_pkg::EAC_PROG: begin
					prog_count <= prog_count - 32'h1;
					if (prog_done)
						state <= eac_pkg::EAC_IDLE;
				end
			endcase
		end
	end

	// array update at the end of an operation
	always_ff @(posedge clock_in) begin
		if (prog_done)
			mem[prog_addr] <= next_byte;
	end

	// registered outputs
	always_ff @(posedge clock_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			io_rdata_out  <= `EAC_RST_BYTE;
			ready_irq_out <= 1'b0;
			cpu_stall_out <= 1'b0;
		end else begin
			io_rdata_out  <= io_re_in ? next_rdata : `EAC_RST_BYTE;
			ready_irq_out <= next_ready_irq;
			cpu_stall_out <= next_stall;
		end
	end

	always_ff @(posedge clock_in or negedge por_n_in) begin
		if (!por_n_in)
			busy_out <= 1'b0;
		else
			busy_out <= next_busy;
	end

endmodule // eac_top

`default_nettype wire

/* eac_monitor.sv */
// checker for the data-memory access block: stalls, busy span, reads, ready request
// assumes a bind onto eac_top with the same atomic cycle count
`timescale 1ns/1ps
`default_nettype none

module eac_monitor #(
	parameter int ATOMIC_CYC = 40
) (
	// clock and resets
	input wire logic       clock_in,
	input wire logic       reset_n_in,
	input wire logic       por_n_in,
	// i/o register port
	input wire logic [5:0] io_addr_in,
	input wire logic [7:0] io_wdata_in,
	input wire logic       io_we_in,
	input wire logic       io_re_in,
	input wire logic [7:0] io_rdata_out,
	// core interface
	input wire logic       global_irq_in,
	input wire logic       ready_irq_out,
	input wire logic       cpu_stall_out,
	input wire logic       busy_out
);
	logic        ctrl_wr;
	logic [15:0] busy_cnt;

	assign ctrl_wr = io_we_in && io_addr_in == 6'h1C;

	// busy span survives chip reset, so only power-on clears it
	always_ff @(posedge clock_in or negedge por_n_in) begin
		if (!por_n_in)
			busy_cnt <= 16'h0000;
		else
			busy_cnt <= busy_out ? busy_cnt + 16'h0001 : 16'h0000;
	end

	default clocking cb @(posedge clock_in); endclocking
	default disable iff (!reset_n_in || !por_n_in);

	a_read_stall_four:
		assert property (ctrl_wr && io_wdata_in == 8'h01 && !busy_out
			|=> cpu_stall_out [*4] ##1 !cpu_stall_out) else $error("read stall length wrong");
	a_prog_stall_two:
		assert property ($rose(busy_out) |-> cpu_stall_out [*2] ##1 !cpu_stall_out)
			else $error("program stall length wrong");
	a_busy_no_stall:
		assert property (busy_out && $past(busy_out, 2) |-> !cpu_stall_out)
			else $error("stall while busy");
	a_start_needs_write:
		assert property ($rose(busy_out) |-> $past(ctrl_wr && io_wdata_in[1]))
			else $error("busy without program write");
	a_busy_min_span:
		assert property ($rose(busy_out) |=> busy_out [*8]) else $error("busy too short");
	a_busy_max_span:
		assert property (busy_cnt <= ATOMIC_CYC + 2) else $error("busy too long");
	a_ctrl_top_zero:
		assert property ($past(io_re_in && io_addr_in == 6'h1C) |-> io_rdata_out[7:6] == 2'b00)
			else $error("control top bits set");
	a_addr_high_zero:
		assert property ($past(io_re_in && io_addr_in == 6'h1F) |-> io_rdata_out[7:1] == 7'h00)
			else $error("high address bits set");
	a_irq_needs_global:
		assert property (ready_irq_out |-> $past(global_irq_in)) else $error("irq without global");
	a_irq_off_busy:
		assert property (busy_out && $past(busy_out) |-> !ready_irq_out)
			else $error("irq while busy");
endmodule // eac_monitor

`default_nettype wire

/* test_eeprom_access_control.sv */
// self-checking bench for the data-memory access block
// assumes eac_top, eac_monitor and eac_cfg.svh compile beside it
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
	$display("Error t=%0t got=%h exp=%h", $time, g, e); end end

module test_eeprom_access_control;
	logic       clock_in;
	logic       reset_n_in;
	logic       por_n_in;
	logic [5:0] io_addr_in;
	logic [7:0] io_wdata_in;
	logic       io_we_in;
	logic       io_re_in;
	logic [7:0] io_rdata_out;
	logic       global_irq_in;
	logic       ready_irq_out;
	logic       cpu_stall_out;
	logic       busy_out;
	int         fails;
	int         n_compared;
	int         cycles;
	int         n;

	eac_top #(.ATOMIC_CYC(40), .SPLIT_CYC(20)) u_dut (
		.clock_in(clock_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in),
		.io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_we_in(io_we_in),
		.io_re_in(io_re_in), .io_rdata_out(io_rdata_out), .global_irq_in(global_irq_in),
		.ready_irq_out(ready_irq_out), .cpu_stall_out(cpu_stall_out), .busy_out(busy_out));

	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end

	task automatic test_done();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	always @(posedge clock_in) begin
		cycles++;
		if (cycles == 4000) begin
			fails++;
			test_done();
		end
	end

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge clock_in);
		io_addr_in = a;
		io_wdata_in = d;
		io_we_in = 1'b1;
		@(negedge clock_in);
		io_we_in = 1'b0;
	endtask

	task automatic rd(input logic [5:0] a, input logic [7:0] e);
		@(negedge clock_in);
		io_addr_in = a;
		io_re_in = 1'b1;
		@(negedge clock_in);
		io_re_in = 1'b0;
		`CHK(io_rdata_out, e)
	endtask

	task automatic idle(input int k);
		repeat (k) @(negedge clock_in);
	endtask

	// busy cycles left from the call until busy_out falls must fall inside lo..hi
	task automatic wait_done(input int lo, input int hi);
		n = 0;
		while (busy_out !== 1'b0 && n < 200) begin
			@(negedge clock_in);
			n++;
		end
		`CHK(n >= lo && n <= hi, 1'b1)
	endtask

	// mode in bits 5:4, ready enable in bit 3
	task automatic prog(input logic [7:0] m);
		wr(6'h1C, m);
		wr(6'h1C, m | 8'h04);
		wr(6'h1C, m | 8'h02);
	endtask

	task automatic fetch(input logic [7:0] e);
		wr(6'h1C, 8'h01);
		`CHK(cpu_stall_out, 1'b1)
		rd(6'h1D, e);
	endtask

	initial begin
		reset_n_in = 1'b0;
		por_n_in = 1'b0;
		io_addr_in = 6'h00;
		io_wdata_in = 8'h00;
		io_we_in = 1'b0;
		io_re_in = 1'b0;
		global_irq_in = 1'b1;
		repeat (12) @(posedge clock_in);
		@(negedge clock_in);
		reset_n_in = 1'b1;
		por_n_in = 1'b1;
		idle(3);
		for (int i = 0; i < 3; i++) begin
			rd(6'h13 + 6'(i), 8'h00);
			wr(6'h13 + 6'(i), 8'hA5 ^ 8'(i));
			rd(6'h13 + 6'(i), 8'hA5 ^ 8'(i));
		end
		rd(6'h1C, 8'h00);
		wr(6'h20, 8'h55);
		rd(6'h20, 8'h00);
		wr(6'h1F, 8'hFF);
		rd(6'h1F, 8'h01);
		wr(6'h1E, 8'hA5);
		rd(6'h1E, 8'hA5);
		wr(6'h1D, 8'h3C);
		rd(6'h1D, 8'h3C);
		wr(6'h1C, 8'h08);
		idle(1);
		`CHK(ready_irq_out, 1'b1)
		prog(8'h08);
		`CHK(busy_out, 1'b1)
		rd(6'h1C, 8'h0E);
		`CHK(ready_irq_out, 1'b0)
		wr(6'h1C, 8'h18);
		wr(6'h1E, 8'h00);
		wr(6'h1C, 8'h09);
		rd(6'h1E, 8'hA5);
		rd(6'h1C, 8'h0A);
		wait_done(24, 42);
		idle(1);
		`CHK(ready_irq_out, 1'b1)
		global_irq_in = 1'b0;
		idle(2);
		`CHK(ready_irq_out, 1'b0)
		fetch(8'h3C);
		prog(8'h10);
		wait_done(8, 22);
		fetch(8'hFF);
		wr(6'h1D, 8'h5A);
		prog(8'h20);
		wait_done(8, 22);
		fetch(8'h5A);
		prog(8'h30);
		`CHK(busy_out, 1'b0)
		for (int k = 2; k < 4; k++) begin
			wr(6'h1C, 8'h04);
			idle(k);
			wr(6'h1C, 8'h02);
			`CHK(busy_out, k == 2)
			if (k == 2)
				wait_done(24, 42);
			else
				rd(6'h1C, 8'h00);
		end
		prog(8'h10);
		reset_n_in = 1'b0;
		idle(2);
		reset_n_in = 1'b1;
		`CHK(busy_out, 1'b1)
		idle(1);
		rd(6'h1C, 8'h12);
		rd(6'h13, 8'h00);
		wait_done(6, 22);
		test_done();
	end
endmodule // test_eeprom_access_control

bind eac_top eac_monitor #(.ATOMIC_CYC(ATOMIC_CYC)) u_mon (
	.clock_in(clock_in), .reset_n_in(reset_n_in), .por_n_in(por_n_in),
	.io_addr_in(io_addr_in), .io_wdata_in(io_wdata_in), .io_we_in(io_we_in),
	.io_re_in(io_re_in), .io_rdata_out(io_rdata_out), .global_irq_in(global_irq_in),
	.ready_irq_out(ready_irq_out), .cpu_stall_out(cpu_stall_out), .busy_out(busy_out));

`default_nettype wire
